// ### include/ffm_map.svh
/*
 * Register map, field positions, reset values and timing figures of the
 * fault flag, event mask and converter control block.
 * Assumes inclusion by bare name from files that need the constants.
 */
`ifndef FFM_MAP_SVH
`define FFM_MAP_SVH

// register offsets on the two-wire bus
`define FFM_ADDR_FAULT_FLAGS 8'h11
`define FFM_ADDR_MASK_A 8'h12
`define FFM_ADDR_MASK_B 8'h13
`define FFM_ADDR_FAULT_MASK 8'h14
`define FFM_ADDR_CONV_CTRL 8'h15
`define FFM_ADDR_CHAN_OFF 8'h16

// reset values and the value read from unmapped offsets
`define FFM_RST_FAULT_FLAGS 8'h00
`define FFM_RST_MASK 8'h00
`define FFM_RST_CONV_CTRL 8'h30
`define FFM_RST_CHAN_OFF 8'h00
`define FFM_RD_UNMAPPED 8'h00

// implemented bits; reserved positions read zero
`define FFM_VALID_FAULT 8'hF9
`define FFM_VALID_MASK_A 8'hF9
`define FFM_VALID_MASK_B 8'h97
`define FFM_VALID_FAULT_MASK 8'hF9
`define FFM_VALID_CONV_CTRL 8'hF0
`define FFM_VALID_CHAN_OFF 8'hFD

// converter control fields
`define FFM_CTRL_ENABLE 7
`define FFM_CTRL_ONE_SHOT 6
`define FFM_CTRL_RES_HI 5
`define FFM_CTRL_RES_LO 4

// channel disable fields
`define FFM_CH_INPUT_CURRENT 7
`define FFM_CH_CHARGE_CURRENT 6
`define FFM_CH_INPUT_VOLTAGE 5
`define FFM_CH_BATTERY_VOLTAGE 4
`define FFM_CH_SYSTEM_VOLTAGE 3
`define FFM_CH_THERMISTOR 2
`define FFM_CH_DIE_TEMP 0

// serial link framing
`define FFM_BITS_PER_BYTE 4'd8
`define FFM_BIT_FIRST 4'd0

// alert pulse width and system clock period
`define FFM_ALERT_PULSE_NS 256000
`define FFM_CLK_PERIOD_NS 20

`endif

// ### include/ffm_pkg.sv
/*
 * Types shared by the fault flag, event mask and converter control block.
 * Assumes the map header supplies all numeric constants.
 */
`default_nettype none
package ffm_pkg;

   typedef struct packed {
      logic input_overvoltage;
      logic thermal_shutdown;
      logic battery_overvoltage;
      logic safety_timer;
      logic system_short;
      logic rb_overload;
      logic rb_input_overvoltage;
      logic rb_battery_low;
   } ffm_fault_status_t;

   typedef struct packed {
      logic conv_done;
      logic input_current_reg;
      logic input_voltage_reg;
      logic thermal_reg;
      logic watchdog_expired_status;
      logic [2:0] charge_phase_status;
      logic power_good;
      logic [2:0] source_detect_status;
      logic [2:0] thermistor_zone_status;
      logic [1:0] current_optimizer_status;
      logic system_floor_voltage;
   } ffm_charger_status_t;

   typedef struct packed {
      logic enable;
      logic one_shot;
      logic [1:0] resolution;
      logic input_current_channel_off;
      logic charge_current_channel_off;
      logic input_voltage_channel_off;
      logic battery_voltage_channel_off;
      logic system_voltage_channel_off;
      logic thermistor_channel_off;
      logic die_temp_channel_off;
   } ffm_conv_ctrl_t;

   typedef struct packed {
      logic wr;
      logic [7:0] addr;
      logic [7:0] data;
   } ffm_link_req_t;

   typedef enum logic [4:0] {
      FFM_L_ADDR = 5'b00001,
      FFM_L_REG = 5'b00010,
      FFM_L_WDATA = 5'b00100,
      FFM_L_RDATA = 5'b01000,
      FFM_L_IGNORE = 5'b10000
   } ffm_link_state_t;

endpackage
`default_nettype wire

// ### design/ffm_top.sv
/*
 * Fault flags, event masks and converter sequencing controls of a battery
 * charger, reached over a two-wire serial bus as a target.
 * Assumes status inputs come from charger logic on clk_sys; the serial clock
 * arrives on scl_clk, which also feeds the bus condition detector.
 */
`timescale 1ns/1ps
`default_nettype none
`include "ffm_map.svh"

// How it works
// - flag bit 7 sets on entry into input overvoltage fault.
// - flag bit 6 sets on entry into die thermal shutdown.
// - flag bit 5 sets on entry into battery overvoltage fault.
// - flag bit 4 sets on rising edge of safety timer expiry.
// - flag bit 3 sets when boost stops switching on overload.
// - flag bit 0 sets on any of three reverse-buck faults.
// - reserved bits of flag, mask and control registers read zero.
// - flag register clears on register reset, not on watchdog expiry.
// - mask A bit 7 gates alert on one-shot conversion completion.
// - mask A bits 6,5,4 gate alerts on regulation loop entries.
// - mask A bit 3 gates alert on watchdog expiry rising edge.
// - mask A bit 0 gates alert on any charge phase change.
// - mask B bit 7 gates alert on any power good toggle.
// - mask B bits 4,2 gate source detect and thermistor changes.
// - mask B bit 1 gates alert on current optimizer rising edge.
// - mask B bit 0 gates alert on floor regulation entry and exit.
// - fault mask bits 7..3 and 0 gate fault edge alerts.
// - control bit 7 enables converter; cleared by reset and watchdog.
// - control bit 6 selects continuous (0) or one-shot (1).
// - control bits 5:4 select resolution 15,14,13,12 bits.
// - control register resets to 30h.
// - channel disable bits 7..2 and 0 skip one channel each.
// - conversion done indication only in one-shot mode, else zero.
module ffm_top #(
   parameter logic [6:0] DEV_ADDR = 7'h2A, // arbitrary target address
   parameter int ALERT_PULSE_CYCLES =
      `FFM_ALERT_PULSE_NS / `FFM_CLK_PERIOD_NS,
   parameter int ALERT_CNT_W = 14
) (
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic register_reset,
   input wire ffm_pkg::ffm_fault_status_t fault_status,
   input wire ffm_pkg::ffm_charger_status_t charger_status,
   input wire logic scl_clk,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe,
   output logic alert_o,
   output logic alert_oe,
   output ffm_pkg::ffm_conv_ctrl_t conv_ctrl,
   output logic conv_done_indication
);
   import ffm_pkg::*;

   // system domain: bus condition detector
   logic scl_s1_reg, scl_s2_reg, sda_s1_reg, sda_s2_reg, sda_s3_reg;
   logic restart_reg, hard_rst_reg;
   wire start_cond = scl_s2_reg & sda_s3_reg & ~sda_s2_reg;
   wire stop_cond = scl_s2_reg & ~sda_s3_reg & sda_s2_reg;
   // link logic held idle from start/stop until scl falls; release while
   // scl is low keeps the release away from any scl edge
   wire restart_next = start_cond | stop_cond | (restart_reg & scl_s2_reg);

   always_ff @(posedge clk_sys) begin
      scl_s1_reg <= scl_clk;
      scl_s2_reg <= scl_s1_reg;
      sda_s1_reg <= sda_i;
      sda_s2_reg <= sda_s1_reg;
      sda_s3_reg <= sda_s2_reg;
      hard_rst_reg <= srst;
      restart_reg <= srst | restart_next;
   end

   wire link_rst = restart_reg;
   wire link_hard_rst = hard_rst_reg;

   // link domain: receive side on rising scl
   ffm_link_state_t state_reg, state_next;
   logic [3:0] bit_cnt_reg;
   logic [7:0] shift_reg;
   logic [7:0] ptr_reg;
   logic req_tgl_reg;
   ffm_link_req_t req_reg;

   wire byte_end = (bit_cnt_reg == `FFM_BITS_PER_BYTE);
   wire addr_hit = (shift_reg[7:1] == DEV_ADDR);
   wire master_ack = ~sda_i;
   wire [7:0] ptr_inc = ptr_reg + 8'h01;
   wire [3:0] bit_cnt_next = byte_end ? `FFM_BIT_FIRST :
      bit_cnt_reg + 4'd1;

   always_comb begin
      state_next = state_reg;
      if (byte_end) begin
         case (state_reg)
            FFM_L_ADDR: begin
               if (!addr_hit)
                  state_next = FFM_L_IGNORE;
               else if (shift_reg[0])
                  state_next = FFM_L_RDATA;
               else
                  state_next = FFM_L_REG;
            end
            FFM_L_REG: state_next = FFM_L_WDATA;
            FFM_L_WDATA: state_next = FFM_L_WDATA;
            FFM_L_RDATA: begin
               if (!master_ack)
                  state_next = FFM_L_IGNORE;
            end
            FFM_L_IGNORE: state_next = FFM_L_IGNORE;
            default: state_next = FFM_L_IGNORE;
         endcase
      end
   end

   wire rd_first = byte_end & (state_reg == FFM_L_ADDR) & addr_hit &
      shift_reg[0];
   wire rd_more = byte_end & (state_reg == FFM_L_RDATA) & master_ack;
   wire wr_byte = byte_end & (state_reg == FFM_L_WDATA);
   wire ptr_load = byte_end & (state_reg == FFM_L_REG);
   wire req_fire = rd_first | rd_more | wr_byte;
   wire [7:0] ptr_next = ptr_load ? shift_reg :
      ((rd_more | wr_byte) ? ptr_inc : ptr_reg);
   ffm_link_req_t req_next;
   assign req_next.wr = wr_byte;
   assign req_next.addr = rd_more ? ptr_inc : ptr_reg;
   assign req_next.data = shift_reg;

   always_ff @(posedge scl_clk or posedge link_rst) begin
      if (link_rst) begin
         state_reg <= FFM_L_ADDR;
         bit_cnt_reg <= `FFM_BIT_FIRST;
         shift_reg <= 8'h00;
      end else begin
         state_reg <= state_next;
         bit_cnt_reg <= bit_cnt_next;
         if (!byte_end)
            shift_reg <= {shift_reg[6:0], sda_i};
      end
   end

   // pointer and request survive repeated starts
   always_ff @(posedge scl_clk or posedge link_hard_rst) begin
      if (link_hard_rst) begin
         ptr_reg <= 8'h00;
         req_tgl_reg <= 1'b0;
         req_reg <= '0;
      end else begin
         ptr_reg <= ptr_next;
         if (req_fire) begin
            req_tgl_reg <= ~req_tgl_reg;
            req_reg <= req_next;
         end
      end
   end

   // link domain: transmit side on falling scl
   logic [7:0] rd_data_reg;
   logic [7:0] tx_reg;
   logic sda_oe_reg;
   wire ack_slot = byte_end & (((state_reg == FFM_L_ADDR) & addr_hit) |
      (state_reg == FFM_L_REG) | (state_reg == FFM_L_WDATA));
   wire tx_load = (state_reg == FFM_L_RDATA) &
      (bit_cnt_reg == `FFM_BIT_FIRST);
   wire tx_shift = (state_reg == FFM_L_RDATA) & ~byte_end & ~tx_load;

   always_ff @(negedge scl_clk or posedge link_rst) begin
      if (link_rst) begin
         sda_oe_reg <= 1'b0;
         tx_reg <= 8'h00;
      end else if (ack_slot) begin
         sda_oe_reg <= 1'b1;
      end else if (tx_load) begin
         // read data settled well inside the scl high phase
         tx_reg <= rd_data_reg;
         sda_oe_reg <= ~rd_data_reg[7];
      end else if (tx_shift) begin
         tx_reg <= {tx_reg[6:0], 1'b0};
         sda_oe_reg <= ~tx_reg[6];
      end else begin
         sda_oe_reg <= 1'b0;
      end
   end

   assign sda_o = 1'b0;
   assign sda_oe = sda_oe_reg;

   // system domain: request crossing by toggle, fields held meanwhile
   logic tgl_s1_reg, tgl_s2_reg, tgl_s3_reg;
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         tgl_s1_reg <= 1'b0;
         tgl_s2_reg <= 1'b0;
         tgl_s3_reg <= 1'b0;
      end else begin
         tgl_s1_reg <= req_tgl_reg;
         tgl_s2_reg <= tgl_s1_reg;
         tgl_s3_reg <= tgl_s2_reg;
      end
   end

   wire req_seen = tgl_s2_reg ^ tgl_s3_reg;
   wire wr_fire = req_seen & req_reg.wr;
   wire rd_fire = req_seen & ~req_reg.wr;
   wire [7:0] wdata = req_reg.data;
   wire sel_flags = (req_reg.addr == `FFM_ADDR_FAULT_FLAGS);
   wire sel_mask_a = (req_reg.addr == `FFM_ADDR_MASK_A);
   wire sel_mask_b = (req_reg.addr == `FFM_ADDR_MASK_B);
   wire sel_fmask = (req_reg.addr == `FFM_ADDR_FAULT_MASK);
   wire sel_ctrl = (req_reg.addr == `FFM_ADDR_CONV_CTRL);
   wire sel_chan = (req_reg.addr == `FFM_ADDR_CHAN_OFF);

   // registers
   logic [7:0] flags_reg, mask_a_reg, mask_b_reg, fmask_reg;
   logic [7:0] ctrl_reg, chan_reg;
   wire reg_rst = srst | register_reset;

   // event detection
   ffm_fault_status_t fault_prev_reg;
   ffm_charger_status_t chg_prev_reg;
   logic primed_reg;
   wire one_shot = ctrl_reg[`FFM_CTRL_ONE_SHOT];
   wire fault_rb = fault_status.rb_overload |
      fault_status.rb_input_overvoltage | fault_status.rb_battery_low;
   wire fault_rb_prev = fault_prev_reg.rb_overload |
      fault_prev_reg.rb_input_overvoltage | fault_prev_reg.rb_battery_low;
   wire [7:0] fault_ev = {8{primed_reg}} & `FFM_VALID_FAULT & {
      fault_status.input_overvoltage & ~fault_prev_reg.input_overvoltage,
      fault_status.thermal_shutdown & ~fault_prev_reg.thermal_shutdown,
      fault_status.battery_overvoltage &
         ~fault_prev_reg.battery_overvoltage,
      fault_status.safety_timer & ~fault_prev_reg.safety_timer,
      fault_status.system_short & ~fault_prev_reg.system_short,
      2'b00,
      fault_rb & ~fault_rb_prev};

   wire wd_rise = charger_status.watchdog_expired_status &
      ~chg_prev_reg.watchdog_expired_status & primed_reg;
   wire [7:0] chg_ev_a = {8{primed_reg}} & `FFM_VALID_MASK_A & {
      charger_status.conv_done & ~chg_prev_reg.conv_done & one_shot,
      charger_status.input_current_reg & ~chg_prev_reg.input_current_reg,
      charger_status.input_voltage_reg & ~chg_prev_reg.input_voltage_reg,
      charger_status.thermal_reg & ~chg_prev_reg.thermal_reg,
      wd_rise,
      2'b00,
      |(charger_status.charge_phase_status ^
         chg_prev_reg.charge_phase_status)};
   wire [7:0] chg_ev_b = {8{primed_reg}} & `FFM_VALID_MASK_B & {
      charger_status.power_good ^ chg_prev_reg.power_good,
      2'b00,
      |(charger_status.source_detect_status ^
         chg_prev_reg.source_detect_status),
      1'b0,
      |(charger_status.thermistor_zone_status ^
         chg_prev_reg.thermistor_zone_status),
      |(charger_status.current_optimizer_status &
         ~chg_prev_reg.current_optimizer_status),
      charger_status.system_floor_voltage ^
         chg_prev_reg.system_floor_voltage};

   // first cycle after reset has no valid history, so no edges then
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         fault_prev_reg <= '0;
         chg_prev_reg <= '0;
         primed_reg <= 1'b0;
      end else begin
         fault_prev_reg <= fault_status;
         chg_prev_reg <= charger_status;
         primed_reg <= 1'b1;
      end
   end

   // flags: set wins over the clear of a read in the same cycle
   wire [7:0] flags_clr = (rd_fire & sel_flags) ? 8'hFF : 8'h00;
   wire [7:0] flags_next = ((flags_reg & ~flags_clr) | fault_ev) &
      `FFM_VALID_FAULT;

   wire [7:0] ctrl_wr = wdata & `FFM_VALID_CONV_CTRL;
   wire [7:0] ctrl_wd_clr = wd_rise ?
      ~(8'h01 << `FFM_CTRL_ENABLE) : 8'hFF;
   wire [7:0] ctrl_next = ((wr_fire & sel_ctrl) ? ctrl_wr : ctrl_reg) &
      ctrl_wd_clr;

   always_ff @(posedge clk_sys) begin
      if (reg_rst) begin
         flags_reg <= `FFM_RST_FAULT_FLAGS;
         mask_a_reg <= `FFM_RST_MASK;
         mask_b_reg <= `FFM_RST_MASK;
         fmask_reg <= `FFM_RST_MASK;
         ctrl_reg <= `FFM_RST_CONV_CTRL;
         chan_reg <= `FFM_RST_CHAN_OFF;
      end else begin
         flags_reg <= flags_next;
         ctrl_reg <= ctrl_next;
         if (wr_fire & sel_mask_a)
            mask_a_reg <= wdata & `FFM_VALID_MASK_A;
         if (wr_fire & sel_mask_b)
            mask_b_reg <= wdata & `FFM_VALID_MASK_B;
         if (wr_fire & sel_fmask)
            fmask_reg <= wdata & `FFM_VALID_FAULT_MASK;
         if (wr_fire & sel_chan)
            chan_reg <= wdata & `FFM_VALID_CHAN_OFF;
      end
   end

   // read mux; unmapped offsets read zero
   wire [7:0] rd_mux = sel_flags ? flags_reg :
      sel_mask_a ? mask_a_reg :
      sel_mask_b ? mask_b_reg :
      sel_fmask ? fmask_reg :
      sel_ctrl ? ctrl_reg :
      sel_chan ? chan_reg : `FFM_RD_UNMAPPED;

   always_ff @(posedge clk_sys) begin
      if (srst)
         rd_data_reg <= 8'h00;
      else if (rd_fire)
         rd_data_reg <= rd_mux;
   end

   // alert: events during a running pulse merge into it
   wire alert_trig = |(fault_ev & ~fmask_reg) |
      |(chg_ev_a & ~mask_a_reg) | |(chg_ev_b & ~mask_b_reg);
   logic [ALERT_CNT_W-1:0] alert_cnt_reg;
   logic alert_reg;
   wire alert_idle = (alert_cnt_reg == '0);
   wire [ALERT_CNT_W-1:0] alert_cnt_next =
      (alert_idle & alert_trig) ? ALERT_CNT_W'(ALERT_PULSE_CYCLES) :
      (alert_idle ? alert_cnt_reg : alert_cnt_reg - 1'b1);

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         alert_cnt_reg <= '0;
         alert_reg <= 1'b0;
      end else begin
         alert_cnt_reg <= alert_cnt_next;
         alert_reg <= (alert_cnt_next != '0);
      end
   end

   assign alert_o = 1'b0;
   assign alert_oe = alert_reg;

   // converter controls
   logic done_ind_reg;
   always_ff @(posedge clk_sys) begin
      if (srst)
         done_ind_reg <= 1'b0;
      else
         done_ind_reg <= charger_status.conv_done & one_shot;
   end

   assign conv_done_indication = done_ind_reg;
   assign conv_ctrl.enable = ctrl_reg[`FFM_CTRL_ENABLE];
   assign conv_ctrl.one_shot = ctrl_reg[`FFM_CTRL_ONE_SHOT];
   assign conv_ctrl.resolution =
      ctrl_reg[`FFM_CTRL_RES_HI:`FFM_CTRL_RES_LO];
   assign conv_ctrl.input_current_channel_off =
      chan_reg[`FFM_CH_INPUT_CURRENT];
   assign conv_ctrl.charge_current_channel_off =
      chan_reg[`FFM_CH_CHARGE_CURRENT];
   assign conv_ctrl.input_voltage_channel_off =
      chan_reg[`FFM_CH_INPUT_VOLTAGE];
   assign conv_ctrl.battery_voltage_channel_off =
      chan_reg[`FFM_CH_BATTERY_VOLTAGE];
   assign conv_ctrl.system_voltage_channel_off =
      chan_reg[`FFM_CH_SYSTEM_VOLTAGE];
   assign conv_ctrl.thermistor_channel_off = chan_reg[`FFM_CH_THERMISTOR];
   assign conv_ctrl.die_temp_channel_off = chan_reg[`FFM_CH_DIE_TEMP];

endmodule
`default_nettype wire

// ### verif/ffm_host.sv
/*
 * Two-wire bus master model that reaches the block's registers.
 * Assumes the bench resolves the open-drain data wire with a pull-up.
 */
`timescale 1ns/1ps
`default_nettype none
module ffm_host (
   output logic scl,
   output logic sda_low,
   input wire logic sda
);
   localparam realtime Q = 31.25;
   localparam realtime H = 62.5;
   logic [7:0] nxt; // byte after the one asked for in the last read

   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end

   // ninth bit stays high longer so the target's next data can settle
   task automatic bit_io(input logic b, input logic last, output logic r);
      #Q sda_low = !b;
      #Q scl = 1'b1;
      #H;
      if (last)
         #H;
      r = sda;
      scl = 1'b0;
   endtask

   task automatic xfer(input logic [7:0] tx, input logic ack_in,
         output logic [7:0] rx, output logic ack);
      for (int i = 7; i >= 0; i--)
         bit_io(tx[i], 1'b0, rx[i]);
      bit_io(ack_in, 1'b1, ack);
   endtask

   // also serves as repeated start: data released while the clock is low
   task automatic start();
      #Q sda_low = 1'b0;
      #Q scl = 1'b1;
      #H sda_low = 1'b1;
      #H scl = 1'b0;
   endtask

   task automatic stop();
      #Q sda_low = 1'b1;
      #Q scl = 1'b1;
      #H sda_low = 1'b0;
      #H;
   endtask

   task automatic wr_reg(input logic [6:0] dev, input logic [7:0] a, d,
         output logic ok);
      logic [7:0] rx;
      logic k0, k1, k2;
      start();
      xfer({dev, 1'b0}, 1'b1, rx, k0);
      xfer(a, 1'b1, rx, k1);
      xfer(d, 1'b1, rx, k2);
      stop();
      ok = !(k0 | k1 | k2);
   endtask

   // first byte acknowledged so the pointer steps; refusal lets go
   task automatic rd_reg(input logic [6:0] dev, input logic [7:0] a,
         output logic [7:0] d, output logic ok);
      logic [7:0] rx;
      logic k0, k1, k2, k3;
      start();
      xfer({dev, 1'b0}, 1'b1, rx, k0);
      xfer(a, 1'b1, rx, k1);
      start();
      xfer({dev, 1'b1}, 1'b1, rx, k2);
      xfer(8'hFF, 1'b0, d, k3);
      xfer(8'hFF, 1'b1, nxt, k3);
      stop();
      ok = !(k0 | k1 | k2);
   endtask
endmodule
`default_nettype wire

// ### verif/ffm_top_sva.sv
/*
 * Concurrent checks on the ports of the fault flag and mask block.
 * Assumes binding into ffm_top; reset is synchronous and active high.
 */
`timescale 1ns/1ps
`default_nettype none
module ffm_top_sva #(
   parameter int ALERT_PULSE_CYCLES = 8
) (
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic register_reset,
   input wire ffm_pkg::ffm_fault_status_t fault_status,
   input wire ffm_pkg::ffm_charger_status_t charger_status,
   input wire logic scl_clk,
   input wire logic sda_o,
   input wire logic sda_oe,
   input wire logic alert_o,
   input wire logic alert_oe,
   input wire ffm_pkg::ffm_conv_ctrl_t conv_ctrl,
   input wire logic conv_done_indication
);
   import ffm_pkg::*;
   localparam logic [10:0] CTRL_RST = 11'h180;
   logic [15:0] run;
   ffm_fault_status_t fs_d;
   ffm_charger_status_t cs_d;
   wire logic moved;
   assign moved = (fault_status != fs_d) || (charger_status != cs_d);

   always_ff @(posedge clk_sys) begin
      fs_d <= fault_status;
      cs_d <= charger_status;
      run <= (srst || !alert_oe) ? 16'h0000 : run + 16'h0001;
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (srst);

   a_alert_width: assert property ($fell(alert_oe) |-> run == ALERT_PULSE_CYCLES)
      else $error("alert pulse width wrong");
   a_alert_bound: assert property (run <= ALERT_PULSE_CYCLES)
      else $error("alert pulse too long");
   a_alert_cause: assert property ($rose(alert_oe) |-> $past(moved))
      else $error("alert without a status change");
   a_wdog_clear: assert property ($rose(charger_status.watchdog_expired_status) |-> ##[1:4] !conv_ctrl.enable)
      else $error("watchdog expiry left converter enabled");
   a_done_oneshot: assert property (conv_done_indication == $past(charger_status.conv_done && conv_ctrl.one_shot))
      else $error("conversion done outside one-shot mode");
   a_reset_out: assert property (disable iff (1'b0) srst |=> !alert_oe && !sda_oe && !conv_done_indication && conv_ctrl == CTRL_RST)
      else $error("outputs not at reset values");
   a_regrst_ctrl: assert property (register_reset |-> ##[1:2] conv_ctrl == CTRL_RST)
      else $error("register reset missed control");
   a_sda_steady: assert property (scl_clk && $past(scl_clk) |-> $stable(sda_oe))
      else $error("data moved while clock high");
   a_od_low: assert property (!sda_o && !alert_o)
      else $error("open-drain level not low");
endmodule

bind ffm_top ffm_top_sva #(.ALERT_PULSE_CYCLES(ALERT_PULSE_CYCLES)) i_sva (
   .clk_sys(clk_sys), .srst(srst), .register_reset(register_reset),
   .fault_status(fault_status), .charger_status(charger_status),
   .scl_clk(scl_clk), .sda_o(sda_o), .sda_oe(sda_oe), .alert_o(alert_o),
   .alert_oe(alert_oe), .conv_ctrl(conv_ctrl),
   .conv_done_indication(conv_done_indication));
`default_nettype wire

// ### verif/tb_ffm_top.sv
/*
 * Self-checking bench for the fault flag, mask and converter control block.
 * Assumes the bus master model; the data wire has a pull-up.
 */
`timescale 1ns/1ps
`default_nettype none
`include "ffm_map.svh"
module tb_ffm_top;
   import ffm_pkg::*;
   localparam logic [6:0] DEV = 7'h2A; // arbitrary target address
   localparam int PULSE = 8;
   localparam int CPOS [10] = '{16, 15, 14, 13, 10, 9, 6, 3, 1, 0};
   localparam logic [7:0] CBIT [10] = '{8'h40, 8'h20, 8'h10, 8'h08, 8'h01,
      8'h80, 8'h10, 8'h04, 8'h02, 8'h01};
   localparam logic [7:0] VALID [5] = '{`FFM_VALID_MASK_A, `FFM_VALID_MASK_B,
      `FFM_VALID_FAULT_MASK, `FFM_VALID_CONV_CTRL, `FFM_VALID_CHAN_OFF};
   logic clk_sys = 1'b0;
   logic srst = 1'b1;
   logic register_reset = 1'b0;
   ffm_fault_status_t fault_status = '0;
   ffm_charger_status_t charger_status = '0;
   logic scl_clk, host_low, sda_o, sda_oe, alert_o, alert_oe;
   logic conv_done_indication;
   ffm_conv_ctrl_t conv_ctrl;
   wire logic sda_line = !(sda_oe || host_low);
   int err_total = 0;
   int total_checks = 0;
   int cycles = 0;

   ffm_host i_host (.scl(scl_clk), .sda_low(host_low), .sda(sda_line));
   ffm_top #(.DEV_ADDR(DEV), .ALERT_PULSE_CYCLES(PULSE)) i_dut (
      .clk_sys(clk_sys), .srst(srst), .register_reset(register_reset),
      .fault_status(fault_status), .charger_status(charger_status),
      .scl_clk(scl_clk), .sda_i(sda_line), .sda_o(sda_o), .sda_oe(sda_oe),
      .alert_o(alert_o), .alert_oe(alert_oe), .conv_ctrl(conv_ctrl),
      .conv_done_indication(conv_done_indication));

   always #10 clk_sys = ~clk_sys;

   task automatic close_out();
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == 60000) begin
         err_total++;
         close_out();
      end
   end

   task automatic check(input string what, input logic [15:0] seen, exp);
      total_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic wr(input logic [7:0] a, d);
      logic ok;
      i_host.wr_reg(DEV, a, d, ok);
      check("write ack", ok, 1'b1);
   endtask

   task automatic rd_chk(input string what, input logic [7:0] a, exp);
      logic ok;
      logic [7:0] d;
      i_host.rd_reg(DEV, a, d, ok);
      check("read ack", ok, 1'b1);
      check(what, d, exp);
   endtask

   // alert width is counted, so a stuck or short pulse shows up too
   task automatic pulse_chk(input string what, input logic exp);
      int n = 0;
      repeat (PULSE + 4) begin
         @(posedge clk_sys);
         #1;
         if (alert_oe === 1'b1)
            n++;
      end
      check(what, 16'(n), exp ? 16'(PULSE) : 16'h0000);
   endtask

   task automatic rst_table();
      for (int i = 0; i < 6; i++) begin
         rd_chk("reset value", 8'h11 + 8'(i),
            i == 4 ? `FFM_RST_CONV_CTRL : 8'h00);
         check("next byte", i_host.nxt,
            i == 3 ? `FFM_RST_CONV_CTRL : 8'h00);
      end
   endtask

   initial begin
      logic [7:0] fb;
      logic ok;
      repeat (20) @(posedge clk_sys);
      srst <= 1'b0;
      repeat (5) @(posedge clk_sys);
      rst_table();
      check("ctrl reset", conv_ctrl, 11'h180);
      $display("reset values done");
      for (int i = 0; i < 5; i++) begin
         wr(8'h12 + 8'(i), 8'hFF);
         rd_chk("reserved bits", 8'h12 + 8'(i), VALID[i]);
      end
      wr(`FFM_ADDR_FAULT_FLAGS, 8'hFF);
      rd_chk("read-only flags", `FFM_ADDR_FAULT_FLAGS, 8'h00);
      check("ctrl all set", conv_ctrl, 11'h7FF);
      wr(`FFM_ADDR_CHAN_OFF, 8'h55);
      check("channel map", conv_ctrl[6:0], 7'h2B);
      for (int r = 0; r < 4; r++) begin
         wr(`FFM_ADDR_CONV_CTRL, 8'h80 | 8'(r << 4));
         check("resolution", conv_ctrl[10:7], {2'b10, 2'(r)});
      end
      $display("register access done");
      @(posedge clk_sys);
      fault_status.system_short <= 1'b1;
      @(posedge clk_sys);
      charger_status.watchdog_expired_status <= 1'b1;
      repeat (4) @(posedge clk_sys);
      #1;
      check("watchdog enable", conv_ctrl[10:7], 4'b0011);
      rd_chk("watchdog flags", `FFM_ADDR_FAULT_FLAGS, 8'h08);
      @(posedge clk_sys);
      fault_status <= 8'h40;
      charger_status <= '0;
      repeat (3) @(posedge clk_sys);
      register_reset <= 1'b1;
      @(posedge clk_sys);
      register_reset <= 1'b0;
      fault_status <= '0;
      rst_table();
      $display("watchdog and register reset done");
      // third pass: continuous mode must stay silent even unmasked
      for (int m = 0; m < 3; m++) begin
         wr(`FFM_ADDR_MASK_A, m == 1 ? 8'h80 : 8'h7F);
         wr(`FFM_ADDR_CONV_CTRL, m == 2 ? 8'h30 : 8'h40);
         @(posedge clk_sys);
         charger_status.conv_done <= 1'b1;
         pulse_chk("done alert", m == 0);
         check("done mark", conv_done_indication, m != 2);
         @(posedge clk_sys);
         charger_status.conv_done <= 1'b0;
      end
      $display("conversion done tests done");
      for (int i = 0; i < 8; i++) begin
         fb = (i >= 3) ? 8'(1 << i) : 8'h01;
         for (int m = 0; m < 2; m++) begin
            wr(`FFM_ADDR_FAULT_MASK, m ? fb : ~fb);
            @(posedge clk_sys);
            fault_status[i] <= 1'b1;
            pulse_chk("fault alert", m == 0);
            rd_chk("flag", `FFM_ADDR_FAULT_FLAGS, fb);
            rd_chk("flag clear", `FFM_ADDR_FAULT_FLAGS, 8'h00);
            @(posedge clk_sys);
            fault_status[i] <= 1'b0;
         end
      end
      $display("fault tests done");
      for (int k = 0; k < 10; k++) begin
         for (int m = 0; m < 2; m++) begin
            wr(k < 5 ? `FFM_ADDR_MASK_A : `FFM_ADDR_MASK_B,
               m ? CBIT[k] : ~CBIT[k]);
            @(posedge clk_sys);
            charger_status[CPOS[k]] <= 1'b1;
            pulse_chk("up", m == 0);
            @(posedge clk_sys);
            charger_status[CPOS[k]] <= 1'b0;
            pulse_chk("down", m == 0 && k >= 4 && k != 8);
         end
      end
      $display("status alert tests done");
      wr(`FFM_ADDR_FAULT_MASK, 8'h48);
      i_host.wr_reg(DEV ^ 7'h01, `FFM_ADDR_FAULT_MASK, 8'hFF, ok);
      check("foreign ack", ok, 1'b0);
      rd_chk("foreign ignored", `FFM_ADDR_FAULT_MASK, 8'h48);
      rd_chk("unmapped read", 8'h20, `FFM_RD_UNMAPPED);
      $display("refusal tests done");
      close_out();
   end
endmodule
`default_nettype wire
